// >>> design/robot_remote_io.v
// Remote command interpreter: samples external sequencer commands and
// drives the matching status outputs. Assumes one 50 MHz clock domain;
// all inputs except gp_output_set_i, clk_en_i and resetn_i are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "remote_io_map.vh"

module robot_remote_io #(
    parameter SLOTS = `SLOT_COUNT,
    parameter VW = `VALUE_WIDTH,
    parameter GPO_WIDTH = 32
)(
    input wire clk_i,
    input wire resetn_i,
    input wire clk_en_i,
    input wire stop_in_i,
    input wire secondary_stop_in_i,
    input wire program_reset_in_i,
    input wire error_clear_in_i,
    input wire cycle_stop_in_i,
    input wire servo_disable_in_i,
    input wire servo_enable_in_i,
    input wire operation_rights_req_i,
    input wire machine_lock_toggle_i,
    input wire evasion_return_req_i,
    input wire gp_output_clear_i,
    input wire [SLOTS-1:0] slot_start_i,
    input wire [SLOTS-1:0] slot_halt_i,
    input wire program_select_strobe_i,
    input wire override_select_strobe_i,
    input wire program_number_out_req_i,
    input wire override_out_req_i,
    input wire mech_out_req_i,
    input wire [VW-1:0] numeric_value_field_i,
    input wire error_event_i,
    input wire emergency_event_i,
    input wire cycle_done_i,
    input wire evasion_done_i,
    input wire [SLOTS-1:0] slot_done_i,
    input wire [GPO_WIDTH-1:0] gp_output_set_i,
    output reg wait_o,
    output reg program_select_enabled_o,
    output reg error_present_o,
    output reg cycle_stop_active_o,
    output reg servo_disabled_echo_o,
    output reg servo_on_o,
    output reg operation_rights_o,
    output reg machine_lock_o,
    output reg evasion_return_active_o,
    output reg emergency_stop_flag_o,
    output reg [SLOTS-1:0] slot_operating_o,
    output reg [SLOTS-1:0] slot_wait_o,
    output reg [VW-1:0] program_number_o,
    output reg [VW-1:0] override_o,
    output reg [VW-1:0] numeric_out_o,
    output reg program_out_flag_o,
    output reg [GPO_WIDTH-1:0] gp_outputs_o
);

////////////////////////////////////////////////////////////////////////////////
// Synchronisers: 15 single commands, per-slot vectors, strobes
localparam NCMD = 15;
localparam NEV = 5;

wire [NCMD-1:0] cmd_raw;
// Order must match the position names in the map header
assign cmd_raw = {
    override_out_req_i, // Position 14
    mech_out_req_i,
    program_number_out_req_i,
    override_select_strobe_i,
    program_select_strobe_i,
    gp_output_clear_i,
    evasion_return_req_i,
    machine_lock_toggle_i,
    operation_rights_req_i,
    servo_enable_in_i,
    servo_disable_in_i,
    cycle_stop_in_i,
    error_clear_in_i,
    program_reset_in_i,
    stop_in_i | secondary_stop_in_i // Position 0; both stops merge here
};

reg [NCMD-1:0] cmd_s1_r;
reg [NCMD-1:0] cmd_s2_r;
reg [NCMD-1:0] cmd_prev_r;
reg [2*SLOTS-1:0] slot_s1_r;
reg [2*SLOTS-1:0] slot_s2_r;
reg [SLOTS-1:0] start_prev_r;
reg [NEV+SLOTS-1:0] ev_s1_r;
reg [NEV+SLOTS-1:0] ev_s2_r;
reg [VW-1:0] val_s1_r;
reg [VW-1:0] val_s2_r;

// Two stages before any logic looks; first stage feeds only the second
always @(posedge clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        cmd_s1_r <= {NCMD{1'b0}};
        cmd_s2_r <= {NCMD{1'b0}};
        cmd_prev_r <= {NCMD{1'b0}};
        slot_s1_r <= {2*SLOTS{1'b0}};
        slot_s2_r <= {2*SLOTS{1'b0}};
        start_prev_r <= {SLOTS{1'b0}};
        ev_s1_r <= {(NEV+SLOTS){1'b0}};
        ev_s2_r <= {(NEV+SLOTS){1'b0}};
        val_s1_r <= `VALUE_ZERO;
        val_s2_r <= `VALUE_ZERO;
    end
    else if (clk_en_i)
    begin
        cmd_s1_r <= cmd_raw;
        cmd_s2_r <= cmd_s1_r;
        cmd_prev_r <= cmd_s2_r;
        slot_s1_r <= {slot_halt_i, slot_start_i};
        slot_s2_r <= slot_s1_r;
        start_prev_r <= slot_s2_r[SLOTS-1:0];
        ev_s1_r <= {slot_done_i, evasion_done_i, cycle_done_i, emergency_event_i,
            error_event_i, 1'b0};
        ev_s2_r <= ev_s1_r;
        val_s1_r <= numeric_value_field_i;
        val_s2_r <= val_s1_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Edge detection: off sample followed by on sample
wire [NCMD-1:0] lvl;
wire [NCMD-1:0] rise;
assign lvl = cmd_s2_r;
assign rise = cmd_s2_r & ~cmd_prev_r;

// Level-qualified commands read the synchronised value itself
wire any_stop = lvl[`CMD_STOP]; // primary and secondary act alike
wire servo_off_lvl = lvl[`CMD_SERVO_OFF];
wire rights_lvl = lvl[`CMD_RIGHTS];
// Edge-qualified commands; a held input fires only once
wire prog_reset_rise = rise[`CMD_PROG_RESET];
wire err_clear_rise = rise[`CMD_ERR_CLEAR];
wire cycle_rise = rise[`CMD_CYCLE];
wire servo_on_rise = rise[`CMD_SERVO_ON];
wire lock_rise = rise[`CMD_LOCK];
wire evasion_rise = rise[`CMD_EVASION];
wire gpo_clear_rise = rise[`CMD_GPO_CLEAR];
wire prog_sel_rise = rise[`CMD_PROG_SEL];
wire ovrd_sel_rise = rise[`CMD_OVRD_SEL];
wire prog_out_rise = rise[`CMD_PROG_OUT];
wire mech_out_rise = rise[`CMD_MECH_OUT];
wire ovrd_out_rise = rise[`CMD_OVRD_OUT];

// Per-slot views: start is edge, halt is level
wire [SLOTS-1:0] slot_start_rise = slot_s2_r[SLOTS-1:0] & ~start_prev_r;
wire [SLOTS-1:0] slot_halt_lvl = slot_s2_r[2*SLOTS-1:SLOTS];
// Internal events, synchronised like the pins
wire err_ev = ev_s2_r[`EV_ERR];
wire emg_ev = ev_s2_r[`EV_EMG];
wire cyc_done = ev_s2_r[`EV_CYC];
wire eva_done = ev_s2_r[`EV_EVA];
wire [SLOTS-1:0] slot_done = ev_s2_r[NEV+SLOTS-1:NEV];

////////////////////////////////////////////////////////////////////////////////
// Global status: stop/wait, errors, servo, lock, rights, returns
reg wait_latched_r;
reg [1:0] out_sel_r;

// Output-field selector test, shared by the flag and the multiplexer
function sel_is;
    input [1:0] cur;
    input [1:0] code;
    begin
        sel_is = (cur == code);
    end
endfunction

always @(posedge clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        wait_o <= 1'b0;
        wait_latched_r <= 1'b0;
        program_select_enabled_o <= 1'b1;
        error_present_o <= 1'b0;
        cycle_stop_active_o <= 1'b0;
        servo_disabled_echo_o <= 1'b0;
        servo_on_o <= 1'b0;
        operation_rights_o <= 1'b0;
        machine_lock_o <= 1'b0;
        evasion_return_active_o <= 1'b0;
        emergency_stop_flag_o <= 1'b0;
        gp_outputs_o <= {GPO_WIDTH{1'b0}};
    end
    else if (clk_en_i)
    begin
        // Wait stands while stop held, and is remembered until program reset
        if (any_stop)
            wait_latched_r <= 1'b1;
        else if (prog_reset_rise)
            wait_latched_r <= 1'b0;
        wait_o <= any_stop | (wait_latched_r & ~prog_reset_rise);
        if (prog_reset_rise & ~any_stop)
            program_select_enabled_o <= 1'b1;
        else if (|slot_start_rise & ~any_stop)
            program_select_enabled_o <= 1'b0;
        // Set beats clear so a new error is never lost
        if (err_ev)
            error_present_o <= 1'b1;
        else if (err_clear_rise)
            error_present_o <= 1'b0;
        // Cycle stop holds until the motion reports done
        if (cycle_rise)
            cycle_stop_active_o <= 1'b1;
        else if (cyc_done)
            cycle_stop_active_o <= 1'b0;
        // Echo follows the pin level only, no memory
        servo_disabled_echo_o <= servo_off_lvl;
        // Servo-off level overrides any servo-on edge
        if (servo_off_lvl | emg_ev)
            servo_on_o <= 1'b0;
        else if (servo_on_rise)
            servo_on_o <= 1'b1;
        // Rights drop as soon as the request level drops
        operation_rights_o <= rights_lvl;
        // Lock flips per edge; holding the input does nothing more
        if (lock_rise)
            machine_lock_o <= ~machine_lock_o;
        // Evasion return refused while any stop is held
        if (evasion_rise & ~any_stop)
            evasion_return_active_o <= 1'b1;
        else if (eva_done | any_stop)
            evasion_return_active_o <= 1'b0;
        // Sticky until reset; no command clears it
        if (emg_ev)
            emergency_stop_flag_o <= 1'b1;
        // Clear edge wins over sets arriving in the same cycle
        if (gpo_clear_rise)
            gp_outputs_o <= {GPO_WIDTH{1'b0}};
        else
            gp_outputs_o <= gp_outputs_o | gp_output_set_i;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Per-slot operating and wait, one copy per slot
genvar g;
generate
    for (g = 0; g < SLOTS; g = g + 1)
    begin : slot_gen
        always @(posedge clk_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                slot_operating_o[g] <= 1'b0;
                slot_wait_o[g] <= 1'b0;
            end
            else if (clk_en_i)
            begin
                // Any stop level holds the slot; start edges are ignored meanwhile
                if (slot_halt_lvl[g] | any_stop | emg_ev)
                    slot_operating_o[g] <= 1'b0;
                else if (slot_start_rise[g] & servo_on_o)
                    slot_operating_o[g] <= 1'b1;
                else if (slot_done[g])
                    slot_operating_o[g] <= 1'b0;
                // Wait mirrors stop levels only; done does not clear it
                slot_wait_o[g] <= slot_halt_lvl[g] | any_stop;
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Numeric fields: latched selections and multiplexed output
always @(posedge clk_i or negedge resetn_i)
begin
    if (!resetn_i)
    begin
        program_number_o <= `PROGRAM_RESET_VALUE;
        override_o <= `OVERRIDE_RESET;
        numeric_out_o <= `VALUE_ZERO;
        program_out_flag_o <= 1'b0;
        out_sel_r <= `OUT_SEL_NONE;
    end
    else if (clk_en_i)
    begin
        // Selections take the synchronised value field
        if (prog_sel_rise)
            program_number_o <= val_s2_r;
        if (ovrd_sel_rise)
            override_o <= val_s2_r;
        // Latest request owns the output field
        if (prog_out_rise)
            out_sel_r <= `OUT_SEL_PROGRAM;
        else if (ovrd_out_rise)
            out_sel_r <= `OUT_SEL_OVERRIDE;
        else if (mech_out_rise)
            out_sel_r <= `OUT_SEL_MECH;
        program_out_flag_o <= prog_out_rise |
            (sel_is(out_sel_r, `OUT_SEL_PROGRAM) & ~ovrd_out_rise & ~mech_out_rise);
        // Select and request in one cycle present the new value at once
        if (prog_out_rise)
            numeric_out_o <= prog_sel_rise ? val_s2_r : program_number_o;
        else if (ovrd_out_rise)
            numeric_out_o <= ovrd_sel_rise ? val_s2_r : override_o;
        else if (mech_out_rise)
            numeric_out_o <= `MECH_NUMBER;
        else if (sel_is(out_sel_r, `OUT_SEL_PROGRAM))
            numeric_out_o <= program_number_o;
        else if (sel_is(out_sel_r, `OUT_SEL_OVERRIDE))
            numeric_out_o <= override_o;
        else if (sel_is(out_sel_r, `OUT_SEL_MECH))
            numeric_out_o <= `MECH_NUMBER;
    end
end

endmodule
`default_nettype wire

// >>> design/remote_io_map.vh
// Constants for the remote command/status handshake block.
// Assumes inclusion by bare name; definitions only.
`ifndef REMOTE_IO_MAP_VH
`define REMOTE_IO_MAP_VH
`define SLOT_COUNT 32
`define VALUE_WIDTH 16
`define VALUE_ZERO 16'h0000
`define OVERRIDE_RESET 16'h0064
`define PROGRAM_RESET_VALUE 16'h0000
`define MECH_NUMBER 16'h0001
`define OUT_SEL_NONE 2'h0
`define OUT_SEL_PROGRAM 2'h1
`define OUT_SEL_OVERRIDE 2'h2
`define OUT_SEL_MECH 2'h3
// Bit positions of the single commands in the synchroniser word
`define CMD_STOP 0
`define CMD_PROG_RESET 1
`define CMD_ERR_CLEAR 2
`define CMD_CYCLE 3
`define CMD_SERVO_OFF 4
`define CMD_SERVO_ON 5
`define CMD_RIGHTS 6
`define CMD_LOCK 7
`define CMD_EVASION 8
`define CMD_GPO_CLEAR 9
`define CMD_PROG_SEL 10
`define CMD_OVRD_SEL 11
`define CMD_PROG_OUT 12
`define CMD_MECH_OUT 13
`define CMD_OVRD_OUT 14
// Bit positions of the internal events in the event word
`define EV_ERR 1
`define EV_EMG 2
`define EV_CYC 3
`define EV_EVA 4
`endif

// >>> test/robot_remote_io_chk.sv
// Checker for the remote command block, bound onto its top module.
// Assumes one clock; latency 3 enabled edges from input to output.
`timescale 1ns/100ps
`default_nettype none
module robot_remote_io_chk #(
    parameter SLOTS = 32,
    parameter VW = 16
)(
    input wire logic clk_i, resetn_i, clk_en_i, stop_in_i, secondary_stop_in_i,
    input wire logic operation_rights_req_i, servo_disable_in_i, machine_lock_toggle_i,
    input wire logic program_select_strobe_i, override_select_strobe_i,
    input wire logic program_number_out_req_i, override_out_req_i, mech_out_req_i,
    input wire logic emergency_event_i, error_event_i,
    input wire logic [SLOTS-1:0] slot_halt_i, slot_wait_o, slot_operating_o,
    input wire logic [VW-1:0] numeric_value_field_i, program_number_o, override_o,
    input wire logic [VW-1:0] numeric_out_o,
    input wire logic wait_o, operation_rights_o, servo_disabled_echo_o, servo_on_o,
    input wire logic machine_lock_o, emergency_stop_flag_o, program_out_flag_o,
    input wire logic error_present_o
);
    // A frozen clock enable stalls the pipeline, so checks pause then
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i || !clk_en_i);
    ////////////////////////////////////////////////////////////////////////////
    AST_WAIT_STOP: assert property ((stop_in_i || secondary_stop_in_i)[*4] |-> wait_o)
        else $error("wait not shown while stop held");
    AST_RIGHTS_ON: assert property (operation_rights_req_i[*4] |-> operation_rights_o)
        else $error("rights not shown while requested");
    AST_RIGHTS_OFF: assert property (!operation_rights_req_i[*4] |-> !operation_rights_o)
        else $error("rights shown without request");
    AST_SERVO_ECHO: assert property (servo_disable_in_i[*4] |-> servo_disabled_echo_o && !servo_on_o)
        else $error("servo disable not honoured");
    AST_SLOT_WAIT: assert property (slot_halt_i[SLOTS-1][*4] |-> slot_wait_o[SLOTS-1])
        else $error("slot wait missing while halted");
    AST_PROG_SEL: assert property ($rose(program_select_strobe_i) ##0 $stable(numeric_value_field_i)[*4]
        |=> program_number_o == numeric_value_field_i)
        else $error("program number not latched");
    AST_OVRD_SEL: assert property ($rose(override_select_strobe_i) ##0 $stable(numeric_value_field_i)[*4]
        |=> override_o == numeric_value_field_i)
        else $error("override not latched");
    AST_LOCK: assert property ($rose(machine_lock_toggle_i) |-> ##3 machine_lock_o != $past(machine_lock_o, 3))
        else $error("lock did not toggle");
    AST_EMG: assert property ($rose(emergency_event_i) |-> ##3 emergency_stop_flag_o)
        else $error("emergency flag late or missing");
    AST_PRG_OUT: assert property ($rose(program_number_out_req_i) && !override_out_req_i && !mech_out_req_i
        |-> ##3 program_out_flag_o && numeric_out_o == program_number_o)
        else $error("program number not presented");
    AST_ERR_SET: assert property ($rose(error_event_i) |-> ##3 error_present_o)
        else $error("error output late or missing");
    // Main scenarios reached
    cover property ($rose(wait_o));
    cover property ($rose(slot_operating_o[0]));
    cover property ($rose(program_out_flag_o));
endmodule
bind robot_remote_io robot_remote_io_chk #(.SLOTS(SLOTS), .VW(VW)) u_chk (.*);
`default_nettype wire

// >>> test/remote_sequencer_model.sv
// External sequencer model driving the edge-type commands and value field.
// Assumes the bench calls its tasks from a process synced to clk_i.
`timescale 1ns/100ps
`default_nettype none
module remote_sequencer_model (
    input wire logic clk_i,
    output logic [11:0] cmd_o,
    output logic [15:0] value_o
);
    initial cmd_o = 12'h000;
    initial value_o = 16'h0000;
    // Rise, hold, then stay low long enough that the next rise is seen
    task automatic pulse(input int idx);
        @(posedge clk_i) cmd_o[idx] <= 1'b1;
        repeat (4) @(posedge clk_i);
        cmd_o[idx] <= 1'b0;
        repeat (4) @(posedge clk_i);
        #5; // Leave the edge so callers compare settled outputs
    endtask
    // Value is set before the strobe rises and kept afterwards
    task automatic sel(input int idx, input logic [15:0] v);
        @(posedge clk_i) value_o <= v;
        pulse(idx);
    endtask
endmodule
`default_nettype wire

// >>> test/test_robot_remote_io.sv
// Self-checking bench for the remote command block.
// Assumes a 50 MHz clock; edge commands come from the sequencer model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_robot_remote_io;
    logic clk_i = 0, resetn_i = 0, clk_en_i = 1, stop = 0, sec_stop = 0, servo_off = 0;
    logic rights = 0, err_ev = 0, emg_ev = 0, cyc_done = 0, ev_done = 0;
    logic [31:0] start = 0, halt = 0, sdone = 0, gpo_set = 0;
    logic [11:0] cmd;
    logic [15:0] val;
    wire [31:0] op, swait, gpo;
    wire [15:0] pnum, ovr, nout;
    wire wt, pse, errp, cyc, echo, son, rts, lock, eva, emg, pflag;
    int errors = 0, tests_run = 0;
    ////////////////////////////////////////////////////////////////////////////
    initial forever #10 clk_i = ~clk_i;
    remote_sequencer_model i_seq (.clk_i(clk_i), .cmd_o(cmd), .value_o(val));
    robot_remote_io i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
        .stop_in_i(stop), .secondary_stop_in_i(sec_stop), .program_reset_in_i(cmd[0]),
        .error_clear_in_i(cmd[1]), .cycle_stop_in_i(cmd[2]), .servo_disable_in_i(servo_off),
        .servo_enable_in_i(cmd[3]), .operation_rights_req_i(rights),
        .machine_lock_toggle_i(cmd[4]), .evasion_return_req_i(cmd[5]),
        .gp_output_clear_i(cmd[6]), .slot_start_i(start), .slot_halt_i(halt),
        .program_select_strobe_i(cmd[7]), .override_select_strobe_i(cmd[8]),
        .program_number_out_req_i(cmd[9]), .override_out_req_i(cmd[10]),
        .mech_out_req_i(cmd[11]), .numeric_value_field_i(val), .error_event_i(err_ev),
        .emergency_event_i(emg_ev), .cycle_done_i(cyc_done), .evasion_done_i(ev_done),
        .slot_done_i(sdone), .gp_output_set_i(gpo_set), .wait_o(wt),
        .program_select_enabled_o(pse), .error_present_o(errp), .cycle_stop_active_o(cyc),
        .servo_disabled_echo_o(echo), .servo_on_o(son), .operation_rights_o(rts),
        .machine_lock_o(lock), .evasion_return_active_o(eva), .emergency_stop_flag_o(emg),
        .slot_operating_o(op), .slot_wait_o(swait), .program_number_o(pnum),
        .override_o(ovr), .numeric_out_o(nout), .program_out_flag_o(pflag),
        .gp_outputs_o(gpo));
    ////////////////////////////////////////////////////////////////////////////
    // Latency is 3 edges; 5 leaves margin, the quarter period avoids the edge race
    task automatic settle;
        repeat (5) @(posedge clk_i);
        #5;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        repeat (5000) @(posedge clk_i);
        errors++;
        conclude;
    end
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        resetn_i <= 1'b1;
        settle;
        `CHK({wt, pse, ovr}, 18'h1_0064)
        @(posedge clk_i) sec_stop <= 1'b1;
        settle;
        `CHK(wt, 1'b1)
        @(posedge clk_i) sec_stop <= 1'b0;
        @(posedge clk_i) stop <= 1'b1;
        settle;
        `CHK(wt, 1'b1)
        @(posedge clk_i) stop <= 1'b0;
        i_seq.pulse(0);
        `CHK({wt, pse}, 2'b01)
        $display("test stop done");
        @(posedge clk_i) err_ev <= 1'b1;
        @(posedge clk_i) err_ev <= 1'b0;
        settle;
        `CHK(errp, 1'b1)
        i_seq.pulse(1);
        `CHK(errp, 1'b0)
        i_seq.pulse(2);
        `CHK(cyc, 1'b1)
        @(posedge clk_i) cyc_done <= 1'b1;
        @(posedge clk_i) cyc_done <= 1'b0;
        settle;
        `CHK(cyc, 1'b0)
        $display("test error and cycle done");
        i_seq.pulse(3);
        `CHK(son, 1'b1)
        @(posedge clk_i) servo_off <= 1'b1;
        settle;
        `CHK({echo, son}, 2'b10)
        @(posedge clk_i) servo_off <= 1'b0;
        settle;
        `CHK(echo, 1'b0)
        i_seq.pulse(3);
        @(posedge clk_i) rights <= 1'b1;
        settle;
        `CHK({son, rts}, 2'b11)
        @(posedge clk_i) rights <= 1'b0;
        settle;
        `CHK(rts, 1'b0)
        $display("test servo and rights done");
        i_seq.pulse(4);
        `CHK(lock, 1'b1)
        i_seq.pulse(4);
        `CHK(lock, 1'b0)
        i_seq.pulse(5);
        `CHK(eva, 1'b1)
        @(posedge clk_i) ev_done <= 1'b1;
        @(posedge clk_i) ev_done <= 1'b0;
        settle;
        `CHK(eva, 1'b0)
        @(posedge clk_i) gpo_set <= 32'h0000_00A5;
        @(posedge clk_i) gpo_set <= 32'h0000_0000;
        settle;
        `CHK(gpo, 32'h0000_00A5)
        i_seq.pulse(6);
        `CHK(gpo, 32'h0000_0000)
        $display("test lock, evasion and outputs done");
        // First and last slot, to catch a bit order slip
        @(posedge clk_i) start <= 32'h8000_0001;
        settle;
        @(posedge clk_i) start <= 32'h0000_0000;
        settle;
        `CHK({pse, op}, 33'h0_8000_0001)
        @(posedge clk_i) halt <= 32'h8000_0000;
        settle;
        `CHK({swait, op}, 64'h8000_0000_0000_0001)
        @(posedge clk_i) halt <= 32'h0000_0000;
        @(posedge clk_i) sdone <= 32'h0000_0001;
        @(posedge clk_i) sdone <= 32'h0000_0000;
        settle;
        `CHK({swait, op}, 64'h0)
        $display("test slots done");
        i_seq.sel(7, 16'h0123);
        `CHK(pnum, 16'h0123)
        i_seq.sel(8, 16'h0042);
        `CHK(ovr, 16'h0042)
        i_seq.pulse(9);
        `CHK({pflag, nout}, 17'h1_0123)
        i_seq.pulse(10);
        `CHK({pflag, nout}, 17'h0_0042)
        i_seq.pulse(11);
        `CHK(nout, 16'h0001)
        $display("test numeric fields done");
        // Frozen enable: a stop applied meanwhile must not show yet
        @(posedge clk_i) clk_en_i <= 1'b0;
        @(posedge clk_i) stop <= 1'b1;
        settle;
        `CHK(wt, 1'b0)
        @(posedge clk_i) clk_en_i <= 1'b1;
        settle;
        `CHK(wt, 1'b1)
        @(posedge clk_i) stop <= 1'b0;
        i_seq.pulse(0);
        `CHK(wt, 1'b0)
        $display("test clock enable done");
        @(posedge clk_i) emg_ev <= 1'b1;
        @(posedge clk_i) emg_ev <= 1'b0;
        settle;
        `CHK({emg, son}, 2'b10)
        $display("test emergency done");
        conclude;
    end
endmodule
`default_nettype wire
